// ==== hw/sac_pkg.sv ====
// Package of constants and types for the successive-approximation converter control
package sac_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SAC_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] SAC_OFF_PINCFG = 8'h04;
  localparam logic [7:0] SAC_OFF_CTRL2 = 8'h08;
  localparam logic [7:0] SAC_OFF_RES_HIGH = 8'h0C;
  localparam logic [7:0] SAC_OFF_RES_LOW = 8'h10;
  localparam logic [7:0] SAC_OFF_FLAGS = 8'h14;
  localparam logic [7:0] SAC_OFF_ENABLES = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SAC_C0_ON = 0;
  localparam int SAC_C0_GO = 1;
  localparam int SAC_C0_CHAN_LSB = 2;
  localparam int SAC_C0_REF_LSB = 6;
  localparam int SAC_C2_CLK_LSB = 0;
  localparam int SAC_C2_ACQ_LSB = 3;
  localparam int SAC_C2_JUSTIFY = 7;
  localparam int SAC_FLAG_DONE = 6;
  localparam logic [7:0] SAC_C0_WMASK = 8'hDD;
  localparam logic [7:0] SAC_PINCFG_MASK = 8'h7F;
  localparam logic [7:0] SAC_C2_MASK = 8'hBF;
  localparam logic [7:0] SAC_CTRL_RESET = 8'h00;
  localparam logic [2:0] SAC_CHAN_NONE = 3'h7;
  localparam logic [9:0] SAC_FULL_SCALE = 10'h3FF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SAC_CLK_PERIOD_NS = 50;
  localparam int SAC_TCY_NS = 200;
  localparam int SAC_TCY_CYCLES = (SAC_TCY_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;
  localparam logic [3:0] SAC_CONV_LAST_TAD = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_RCDLY = 2'h1,
    SAC_ACQ = 2'h3,
    SAC_CONV = 2'h2
  } sac_state_t;

  typedef struct packed {
    logic [2:0] chan_sel;
    logic ref_pos_ext;
    logic ref_neg_ext;
    logic sample_on;
    logic [9:0] dac_code;
  } sac_analog_t;

endpackage : sac_pkg

// ==== hw/sac_top.sv ====
// Converter control block: APB registers, clock division, acquisition and sequencing
`timescale 1ns/1ps

module sac_top
  import sac_pkg::*;
#(
  parameter int TCY_CYCLES = SAC_TCY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_clk_tick,
  input wire logic comp_above,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_digital_in,
  output sac_analog_t analog_ctl,
  output logic conv_done_irq_req
);

  // Start delay counter is three bits wide
  if (TCY_CYCLES < 1 || TCY_CYCLES > 7) begin : g_bad_tcy
    $error("TCY_CYCLES must lie in 1..7");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sac_state_t st;
    logic [7:0] ctrl0;
    logic [6:0] pincfg;
    logic [7:0] ctrl2;
    logic done_flag;
    logic irq_en;
    logic [6:0] div_cnt;
    logic [4:0] tad_cnt;
    logic [3:0] conv_cnt;
    logic [2:0] dly_cnt;
    logic [9:0] sar;
    logic [31:0] rdata;
    logic slverr;
  } sac_regs_t;

  sac_regs_t s_reg;
  sac_regs_t s_next;
  logic [7:0] res_high_reg;
  logic [7:0] res_low_reg;
  logic res_load;
  logic [9:0] res_value;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] clk_divisor(input logic [2:0] code);
    case (code)
      3'h0: clk_divisor = 7'h02;
      3'h1: clk_divisor = 7'h08;
      3'h2: clk_divisor = 7'h20;
      3'h4: clk_divisor = 7'h04;
      3'h5: clk_divisor = 7'h10;
      3'h6: clk_divisor = 7'h40;
      default: clk_divisor = 7'h00;
    endcase
  endfunction : clk_divisor

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction : acq_tads

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  logic conv_on;
  logic busy;
  logic rc_mode;
  logic [2:0] chan;
  logic [2:0] clk_code;
  logic [2:0] acq_code;
  logic tad_tick;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic start_req;
  logic [7:0] wbyte;
  logic [31:0] rd_word;

  assign conv_on = s_reg.ctrl0[SAC_C0_ON];
  assign busy = (s_reg.st != SAC_IDLE);
  assign chan = s_reg.ctrl0[SAC_C0_CHAN_LSB +: 3];
  assign clk_code = s_reg.ctrl2[SAC_C2_CLK_LSB +: 3];
  assign acq_code = s_reg.ctrl2[SAC_C2_ACQ_LSB +: 3];
  assign rc_mode = (clk_code[1:0] == 2'h3);
  assign wbyte = pwdata[7:0];
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // Oscillator divider tick, or the RC tick once the start delay has passed
  assign tad_tick = rc_mode ? (rc_clk_tick && s_reg.st != SAC_RCDLY)
                            : (s_reg.div_cnt == clk_divisor(clk_code) - 7'h01);

  // ----------------------------------------------------------------
  // APB read mux and address check
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    if (reg_hit(paddr, SAC_OFF_CTRL0)) begin
      rd_word[7:0] = (s_reg.ctrl0 & SAC_C0_WMASK) | {6'h00, busy && conv_on, 1'b0};
    end else if (reg_hit(paddr, SAC_OFF_PINCFG)) begin
      rd_word[6:0] = s_reg.pincfg;
    end else if (reg_hit(paddr, SAC_OFF_CTRL2)) begin
      rd_word[7:0] = s_reg.ctrl2 & SAC_C2_MASK;
    end else if (reg_hit(paddr, SAC_OFF_RES_HIGH)) begin
      rd_word[7:0] = res_high_reg;
    end else if (reg_hit(paddr, SAC_OFF_RES_LOW)) begin
      rd_word[7:0] = res_low_reg;
    end else if (reg_hit(paddr, SAC_OFF_FLAGS)) begin
      rd_word[SAC_FLAG_DONE] = s_reg.done_flag;
    end else if (reg_hit(paddr, SAC_OFF_ENABLES)) begin
      rd_word[SAC_FLAG_DONE] = s_reg.irq_en;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    res_load = 1'b0;
    res_value = s_reg.sar;
    start_req = 1'b0;

    // Read data sampled in setup so prdata is a flop in the access phase
    if (rd_setup) begin
      s_next.rdata = rd_word;
      s_next.slverr = !addr_ok;
    end

    if (wr_en) begin
      if (reg_hit(paddr, SAC_OFF_CTRL0)) begin
        s_next.ctrl0 = wbyte & SAC_C0_WMASK;
        start_req = wbyte[SAC_C0_GO] && wbyte[SAC_C0_ON];
      end else if (reg_hit(paddr, SAC_OFF_PINCFG)) begin
        s_next.pincfg = wbyte[6:0];
      end else if (reg_hit(paddr, SAC_OFF_CTRL2)) begin
        s_next.ctrl2 = wbyte & SAC_C2_MASK;
      end else if (reg_hit(paddr, SAC_OFF_FLAGS)) begin
        s_next.done_flag = wbyte[SAC_FLAG_DONE];
      end else if (reg_hit(paddr, SAC_OFF_ENABLES)) begin
        s_next.irq_en = wbyte[SAC_FLAG_DONE];
      end
    end

    // Divider runs only while sequencing, so each run starts on a full period
    if (!busy || tad_tick || rc_mode) begin
      s_next.div_cnt = 7'h00;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 7'h01;
    end

    case (s_reg.st)
      SAC_IDLE: begin
        if (start_req) begin
          s_next.tad_cnt = 5'h00;
          s_next.conv_cnt = 4'h0;
          s_next.dly_cnt = 3'h0;
          if (rc_mode) begin
            s_next.st = SAC_RCDLY;
          end else if (acq_tads(acq_code) != 5'h00) begin
            s_next.st = SAC_ACQ;
          end else begin
            s_next.st = SAC_CONV;
          end
        end
      end
      SAC_RCDLY: begin
        s_next.dly_cnt = s_reg.dly_cnt + 3'h1;
        if (s_reg.dly_cnt == 3'(TCY_CYCLES - 1)) begin
          s_next.st = (acq_tads(acq_code) != 5'h00) ? SAC_ACQ : SAC_CONV;
        end
      end
      SAC_ACQ: begin
        if (tad_tick) begin
          s_next.tad_cnt = s_reg.tad_cnt + 5'h01;
          if (s_reg.tad_cnt == acq_tads(acq_code) - 5'h01) begin
            s_next.st = SAC_CONV;
          end
        end
      end
      SAC_CONV: begin
        if (tad_tick) begin
          s_next.conv_cnt = s_reg.conv_cnt + 4'h1;
          if (s_reg.conv_cnt == 4'h0) begin
            s_next.sar = 10'h200;
          end else begin
            // Keep or drop the trial bit, then try the next lower one
            if (!comp_above) begin
              s_next.sar[SAC_CONV_LAST_TAD - s_reg.conv_cnt] = 1'b0;
            end
            if (s_reg.conv_cnt != SAC_CONV_LAST_TAD) begin
              s_next.sar[SAC_CONV_LAST_TAD - s_reg.conv_cnt - 4'h1] = 1'b1;
            end
          end
          if (s_reg.conv_cnt == SAC_CONV_LAST_TAD) begin
            res_load = 1'b1;
            res_value = (chan == SAC_CHAN_NONE) ? SAC_FULL_SCALE : s_next.sar;
            s_next.st = SAC_IDLE;
          end
        end
      end
      default: s_next.st = SAC_IDLE;
    endcase

    // Hardware set wins over a software clear in the same cycle
    if (res_load) begin
      s_next.done_flag = 1'b1;
    end

    // Disabling the converter abandons any conversion
    if (!s_next.ctrl0[SAC_C0_ON]) begin
      s_next.st = SAC_IDLE;
    end
    s_next.ctrl0[SAC_C0_GO] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: SAC_IDLE, ctrl0: SAC_CTRL_RESET, ctrl2: SAC_CTRL_RESET,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Results carry no reset so their content survives any reset
  always_ff @(posedge pclk) begin
    if (res_load) begin
      if (s_reg.ctrl2[SAC_C2_JUSTIFY]) begin
        res_high_reg <= {6'h00, res_value[9:8]};
        res_low_reg <= res_value[7:0];
      end else begin
        res_high_reg <= res_value[9:2];
        res_low_reg <= {res_value[1:0], 6'h00};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_reg.rdata;
  assign pslverr = s_reg.slverr;
  assign pready = 1'b1;
  assign pin_digital_in = pin_in & s_reg.pincfg;
  assign analog_ctl.chan_sel = chan;
  assign analog_ctl.ref_pos_ext = s_reg.ctrl0[SAC_C0_REF_LSB];
  assign analog_ctl.ref_neg_ext = s_reg.ctrl0[SAC_C0_REF_LSB + 1];
  assign analog_ctl.sample_on = conv_on && s_reg.st != SAC_CONV;
  assign analog_ctl.dac_code = s_reg.sar;
  assign conv_done_irq_req = s_reg.done_flag && s_reg.irq_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_immediate: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SAC_IDLE && start_req && !rc_mode && acq_code == 3'h0)
      |=> s_reg.st == SAC_CONV)
    else $error("zero acquisition did not start conversion at once");

  a_start_acquire: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SAC_IDLE && start_req && !rc_mode && acq_code != 3'h0)
      |=> s_reg.st == SAC_ACQ && analog_ctl.sample_on)
    else $error("nonzero acquisition did not sample first");

  a_rc_delay: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(s_reg.st) == SAC_RCDLY && s_reg.st != SAC_RCDLY && conv_on)
      |-> $past(s_reg.dly_cnt) == 3'(TCY_CYCLES - 1))
    else $error("RC clock start delay has the wrong length");

  a_off_aborts: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_on |-> s_reg.st == SAC_IDLE)
    else $error("converter active while disabled");

  a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
    res_load |=> s_reg.done_flag && s_reg.st == SAC_IDLE && (analog_ctl.sample_on || !conv_on))
    else $error("completion did not set flag and clear status");

  a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SAC_CONV && $past(s_reg.st) != SAC_CONV) |-> s_reg.conv_cnt == 4'h0)
    else $error("conversion did not start from its first period");

  a_conv_end: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(s_reg.st) == SAC_CONV && s_reg.st == SAC_IDLE && conv_on)
      |-> $past(s_reg.conv_cnt) == SAC_CONV_LAST_TAD)
    else $error("conversion ended before eleven periods");

  a_unimpl_full: assert property (@(posedge pclk) disable iff (!presetn)
    (res_load && chan == SAC_CHAN_NONE && s_reg.ctrl2[SAC_C2_JUSTIFY])
      |=> res_high_reg == 8'h03 && res_low_reg == 8'hFF)
    else $error("unimplemented channel did not give full scale");

  a_pin_analog: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_digital_in & ~s_reg.pincfg) == 7'h00)
    else $error("analog pin read as digital one");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.ctrl0[5] == 1'b0 && s_reg.ctrl2[6] == 1'b0)
    else $error("unimplemented control bit set");

endmodule : sac_top

// ==== dv/sac_analog_model.sv ====
// Far-side model: channel levels, hold capacitor, comparator and RC conversion clock
`timescale 1ns/1ps
module sac_analog_model
  import sac_pkg::*;
#(
  parameter int RC_PERIOD = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire sac_analog_t analog_ctl,
  input wire logic [6:0][9:0] levels,
  output logic comp_above,
  output logic rc_clk_tick
);
  logic [9:0] held_reg;
  int rc_cnt = 0;

  // ----------------------------------------------------------------
  // Sample and hold
  // ----------------------------------------------------------------
  // Hold tracks the routed channel only while sampling, then freezes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_reg <= 10'h000;
    end else if (analog_ctl.sample_on) begin
      held_reg <= (analog_ctl.chan_sel == SAC_CHAN_NONE) ? 10'h3FF
                  : levels[analog_ctl.chan_sel];
    end
  end

  assign comp_above = (held_reg >= analog_ctl.dac_code);

  // ----------------------------------------------------------------
  // RC oscillator
  // ----------------------------------------------------------------
  // Free running, it keeps going whatever the converter does
  always @(posedge pclk) begin
    rc_cnt <= (rc_cnt == RC_PERIOD - 1) ? 0 : rc_cnt + 1;
    rc_clk_tick <= (rc_cnt == RC_PERIOD - 1);
  end
endmodule : sac_analog_model

// ==== dv/sar_adc_control_tb_top.sv ====
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
module sar_adc_control_tb_top
  import sac_pkg::*;
;
  localparam int TCY = 2;
  localparam int RC_P = 5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, comp_above, rc_tick, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] pin_in, pin_dig;
  logic [6:0][9:0] levels;
  sac_analog_t actl;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  sac_top #(.TCY_CYCLES(TCY)) u_sac_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_clk_tick(rc_tick), .comp_above(comp_above),
    .pin_in(pin_in), .pin_digital_in(pin_dig), .analog_ctl(actl), .conv_done_irq_req(irq));
  sac_analog_model #(.RC_PERIOD(RC_P)) u_sac_analog_model (.pclk(pclk), .presetn(presetn),
    .analog_ctl(actl), .levels(levels), .comp_above(comp_above), .rc_clk_tick(rc_tick));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rdchk(SAC_OFF_CTRL0, 32'h0);
    rdchk(SAC_OFF_PINCFG, 32'h0);
    rdchk(SAC_OFF_CTRL2, 32'h0);
    rdchk(SAC_OFF_FLAGS, 32'h0);
    rdchk(SAC_OFF_ENABLES, 32'h0);
    apb(1'b1, 8'h1C, 32'hFF);
    check({31'h0, err}, 32'h1);
    rdchk(8'h1C, 32'h0);
  endtask : t_reset_values

  task automatic t_reserved_bits;
    apb(1'b1, SAC_OFF_PINCFG, 32'hFF);
    rdchk(SAC_OFF_PINCFG, 32'h7F);
    apb(1'b1, SAC_OFF_CTRL2, 32'hFF);
    rdchk(SAC_OFF_CTRL2, 32'hBF);
    apb(1'b1, SAC_OFF_ENABLES, 32'hFF);
    rdchk(SAC_OFF_ENABLES, 32'h40);
    // Start request without the enable bit must stay idle
    apb(1'b1, SAC_OFF_CTRL0, 32'hFE);
    rdchk(SAC_OFF_CTRL0, 32'hDC);
  endtask : t_reserved_bits

  task automatic t_pins;
    pin_in <= 7'h7F;
    apb(1'b1, SAC_OFF_PINCFG, 32'h55);
    @(negedge pclk);
    check({25'h0, pin_dig}, 32'h55);
    apb(1'b1, SAC_OFF_PINCFG, 32'h2A);
    @(negedge pclk);
    check({25'h0, pin_dig}, 32'h2A);
    @(posedge pclk);
    pin_in <= 7'h00;
    @(negedge pclk);
    check({25'h0, pin_dig}, 32'h0);
  endtask : t_pins

  task automatic t_refs;
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, SAC_OFF_CTRL0, {24'h0, 2'(v), 1'b0, 3'(v + 3), 2'b00});
      @(negedge pclk);
      check({31'h0, actl.ref_pos_ext}, 32'(v % 2));
      check({31'h0, actl.ref_neg_ext}, 32'(v / 2));
      check({29'h0, actl.chan_sel}, 32'(v + 3));
    end
  endtask : t_refs

  task automatic convert(input logic [2:0] ch, input logic [7:0] ctl2);
    logic [9:0] r;
    int t0, lo, hi, n;
    r = (ch == SAC_CHAN_NONE) ? SAC_FULL_SCALE : levels[ch];
    n = (ctl2[1:0] == 2'h3) ? RC_P : divs[ctl2[2:0]];
    lo = (acqs[ctl2[5:3]] + 11) * n;
    hi = lo + 3;
    if (ctl2[1:0] == 2'h3) begin
      lo = lo - n + TCY;
      hi = hi + n + TCY;
    end
    apb(1'b1, SAC_OFF_PINCFG, 32'h0);
    apb(1'b1, SAC_OFF_CTRL2, {24'h0, ctl2});
    apb(1'b1, SAC_OFF_FLAGS, 32'h0);
    // Channel picked ahead of the start, so a zero sample time still holds it
    apb(1'b1, SAC_OFF_CTRL0, {24'h0, 3'h0, ch, 2'b01});
    apb(1'b1, SAC_OFF_CTRL0, {24'h0, 3'h0, ch, 2'b11});
    t0 = cyc;
    rdchk(SAC_OFF_CTRL0, {24'h0, 3'h0, ch, 2'b11});
    while (irq !== 1'b1 && cyc - t0 < 3000) @(negedge pclk);
    check({31'h0, (cyc - t0 >= lo) && (cyc - t0 <= hi)}, 32'h1);
    rdchk(SAC_OFF_CTRL0, {24'h0, 3'h0, ch, 2'b01});
    rdchk(SAC_OFF_FLAGS, 32'h40);
    rdchk(SAC_OFF_RES_HIGH, ctl2[7] ? {30'h0, r[9:8]} : {24'h0, r[9:2]});
    rdchk(SAC_OFF_RES_LOW, ctl2[7] ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h0});
    apb(1'b1, SAC_OFF_FLAGS, 32'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    repeat (2 * n) @(posedge pclk);
  endtask : convert

  task automatic t_abort;
    apb(1'b1, SAC_OFF_CTRL2, 32'h36);
    apb(1'b1, SAC_OFF_CTRL0, 32'h07);
    repeat (20) @(posedge pclk);
    apb(1'b1, SAC_OFF_CTRL0, 32'h04);
    rdchk(SAC_OFF_CTRL0, 32'h04);
    repeat (2100) @(posedge pclk);
    rdchk(SAC_OFF_FLAGS, 32'h0);
  endtask : t_abort

  task automatic t_reset_mid;
    logic [31:0] keep;
    rdchk(SAC_OFF_CTRL0, 32'h04);
    // Last completed conversion was channel 2, left justified
    rdchk(SAC_OFF_RES_HIGH, {24'h0, levels[2][9:2]});
    keep = rd;
    apb(1'b1, SAC_OFF_CTRL0, 32'h07);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(SAC_OFF_CTRL0, 32'h0);
    rdchk(SAC_OFF_CTRL2, 32'h0);
    rdchk(SAC_OFF_RES_HIGH, keep);
    repeat (2100) @(posedge pclk);
    rdchk(SAC_OFF_FLAGS, 32'h0);
  endtask : t_reset_mid

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc >= 90000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pin_in} = '0;
    levels = {10'h3FE, 10'h001, 10'h155, 10'h2AA, 10'h200, 10'h1FF, 10'h2A5};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_reserved_bits();
    t_pins();
    t_refs();
    // Every clock code, RC ones included, then every sample time
    for (int i = 0; i < 8; i++) begin
      convert(3'(i), {1'b1, 3'h1, 3'(i)});
    end
    for (int i = 0; i < 8; i++) begin
      convert(3'(i) ^ 3'h5, {1'b0, 3'(i), 3'h0});
    end
    t_abort();
    t_reset_mid();
    stop_test();
  end
endmodule : sar_adc_control_tb_top
